// file: common/t2crb_pkg.sv
// package for the timer 2 capture/reload/baud block: map, fields, resets, state
package t2crb_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [9:0] T2CRB_IDX_CONTROL   = 10'h0c8;
	localparam logic [9:0] T2CRB_IDX_MODE      = 10'h0c9;
	localparam logic [9:0] T2CRB_IDX_RCAP_LOW  = 10'h0ca;
	localparam logic [9:0] T2CRB_IDX_RCAP_HIGH = 10'h0cb;
	localparam logic [9:0] T2CRB_IDX_COUNT_LOW = 10'h0cc;
	localparam logic [9:0] T2CRB_IDX_COUNT_HIGH = 10'h0cd;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int T2CRB_CTL_OVF    = 7;
	localparam int T2CRB_CTL_EXT    = 6;
	localparam int T2CRB_CTL_RXSEL  = 5;
	localparam int T2CRB_CTL_TXSEL  = 4;
	localparam int T2CRB_CTL_EXEN   = 3;
	localparam int T2CRB_CTL_RUN    = 2;
	localparam int T2CRB_CTL_CTSEL  = 1;
	localparam int T2CRB_CTL_CPRL   = 0;
	localparam int T2CRB_MOD_HC_LSB = 4;
	localparam int T2CRB_MOD_CCLR   = 3;
	localparam int T2CRB_MOD_OE     = 1;
	localparam int T2CRB_MOD_DOWN_COUNT_ENABLE   = 0;

	// ----------------------------------------------------------------
	// reset values and tick dividers (pclk cycles per count)
	// ----------------------------------------------------------------
	localparam logic [7:0]  T2CRB_RESET_BYTE  = 8'h00;
	localparam logic [15:0] T2CRB_RESET_WORD  = 16'h0000;
	localparam logic [15:0] T2CRB_COUNT_MAX   = 16'hffff;
	localparam logic [3:0]  T2CRB_DIV_SLOW    = 4'hc;
	localparam logic [3:0]  T2CRB_DIV_FAST    = 4'h4;
	localparam logic [3:0]  T2CRB_DIV_BAUD    = 4'h2;

	typedef struct packed {
		logic ovf_flag;
		logic ext_flag;
		logic rx_baud_select;
		logic tx_baud_select;
		logic external_trigger_enable;
		logic run_control;
		logic counter_timer_select;
		logic capture_reload_select;
	} t2crb_ctl_type;

	typedef struct packed {
		logic [3:0] auto_clear_ext_irq;
		logic       capture_clear_enable;
		logic       clock_out_enable;
		logic       down_count_enable;
	} t2crb_mode_type;

	typedef struct packed {
		t2crb_ctl_type  ctl;
		t2crb_mode_type mode;
		logic [15:0]    rcap;
		logic [15:0]    count;
		logic [3:0]     presc;
		logic           trig_s1;
		logic           trig_s2;
		logic           trig_prev;
		logic           cnt_s1;
		logic           cnt_s2;
		logic           cnt_prev;
		logic           clk_out;
		logic           rx_tick;
		logic           tx_tick;
		logic [3:0]     irq_clear;
		logic [31:0]    rdata;
	} t2crb_state_type;

endpackage

// file: src/t2crb_timer.sv
// timer 2 with capture, auto-reload, up/down count, baud ticks and clock out
`timescale 1ns/1ps

module t2crb_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        trigger_pin,
	input  wire logic        count_input_pin,
	input  wire logic        tick_speed_select,
	input  wire logic        timer1_overflow,
	input  wire logic [3:0]  ext_irq_ack,
	output logic      [3:0]  ext_irq_clear,
	output logic             rx_baud_tick,
	output logic             tx_baud_tick,
	output logic             clock_out,
	output logic             clock_out_oe,
	output logic             timer_irq
);

	t2crb_pkg::t2crb_state_type s_q;
	t2crb_pkg::t2crb_state_type s_d;

	logic        wr_en;
	logic        wr_ctl;
	logic        wr_mode;
	logic        wr_cnt;
	logic        wr_rcap;
	logic        hit;
	logic        baud;
	logic        trig_fall;
	logic        cnt_fall;
	logic        tick;
	logic        down;
	logic        dn_mode;
	logic        up_ovf;
	logic        dn_match;
	logic        ovf;
	logic        reload_mode;
	logic        edge_act;
	logic [3:0]  div;
	logic [31:0] rd_mux;

	function automatic logic idx_hit(input logic [11:0] a, input logic [9:0] idx);
		return (a[11:2] == idx) && (a[1:0] == 2'b00);
	endfunction

	// ----------------------------------------------------------------
	// apb slave: zero wait states, error on unmapped access
	// ----------------------------------------------------------------
	assign hit = idx_hit(paddr, t2crb_pkg::T2CRB_IDX_CONTROL)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_MODE)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_LOW)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_HIGH)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_LOW)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_HIGH);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_en   = psel & penable & pwrite;
	assign wr_ctl  = wr_en & idx_hit(paddr, t2crb_pkg::T2CRB_IDX_CONTROL);
	assign wr_mode = wr_en & idx_hit(paddr, t2crb_pkg::T2CRB_IDX_MODE);
	assign wr_cnt  = wr_en & (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_LOW)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_HIGH));
	assign wr_rcap = wr_en & (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_LOW)
		| idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_HIGH));

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_CONTROL)) begin
			rd_mux[7:0] = s_q.ctl;
		end
		if (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_MODE)) begin
			rd_mux[7:0] = {s_q.mode.auto_clear_ext_irq, s_q.mode.capture_clear_enable,
				1'b0, s_q.mode.clock_out_enable, s_q.mode.down_count_enable};
		end
		if (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_LOW)) begin
			rd_mux[7:0] = s_q.rcap[7:0];
		end
		if (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_HIGH)) begin
			rd_mux[7:0] = s_q.rcap[15:8];
		end
		if (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_LOW)) begin
			rd_mux[7:0] = s_q.count[7:0];
		end
		if (idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_HIGH)) begin
			rd_mux[7:0] = s_q.count[15:8];
		end
	end

	// ----------------------------------------------------------------
	// timer decode
	// ----------------------------------------------------------------
	assign baud        = s_q.ctl.rx_baud_select | s_q.ctl.tx_baud_select;
	assign trig_fall   = s_q.trig_prev & ~s_q.trig_s2;
	assign cnt_fall    = s_q.cnt_prev & ~s_q.cnt_s2;
	assign reload_mode = baud | ~s_q.ctl.capture_reload_select;
	assign dn_mode     = s_q.mode.down_count_enable & reload_mode & ~baud;
	// trigger high counts up, low counts down
	assign down        = dn_mode & ~s_q.trig_s2;
	// with down count on in auto-reload mode outside baud mode, the trigger steers direction and does not reload
	assign edge_act    = trig_fall & s_q.ctl.external_trigger_enable & ~baud
		& ~dn_mode;

	always_comb begin
		if (baud) begin
			div = t2crb_pkg::T2CRB_DIV_BAUD;
		end else if (tick_speed_select) begin
			div = t2crb_pkg::T2CRB_DIV_FAST;
		end else begin
			div = t2crb_pkg::T2CRB_DIV_SLOW;
		end
	end

	// >= rather than == so a divider change mid-count cannot strand the prescaler
	assign tick = s_q.ctl.run_control & ((baud | ~s_q.ctl.counter_timer_select)
		? (s_q.presc >= 4'(div - 4'h1)) : cnt_fall);
	assign up_ovf   = tick & ~down & (s_q.count == t2crb_pkg::T2CRB_COUNT_MAX);
	assign dn_match = tick & down & (s_q.count == s_q.rcap);
	assign ovf      = up_ovf | dn_match;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.trig_s1   = trigger_pin;
		s_d.trig_s2   = s_q.trig_s1;
		s_d.trig_prev = s_q.trig_s2;
		s_d.cnt_s1    = count_input_pin;
		s_d.cnt_s2    = s_q.cnt_s1;
		s_d.cnt_prev  = s_q.cnt_s2;

		if (!s_q.ctl.run_control || s_q.presc >= 4'(div - 4'h1)) begin
			s_d.presc = 4'h0;
		end else begin
			s_d.presc = 4'(s_q.presc + 4'h1);
		end

		if (up_ovf) begin
			s_d.count = reload_mode ? s_q.rcap : t2crb_pkg::T2CRB_RESET_WORD;
		end else if (dn_match) begin
			s_d.count = t2crb_pkg::T2CRB_COUNT_MAX;
		end else if (tick) begin
			s_d.count = down ? 16'(s_q.count - 16'h0001) : 16'(s_q.count + 16'h0001);
		end

		if (edge_act) begin
			if (s_q.ctl.capture_reload_select) begin
				s_d.rcap = s_q.count;
				if (s_q.mode.capture_clear_enable) begin
					s_d.count = t2crb_pkg::T2CRB_RESET_WORD;
				end
			end else begin
				s_d.count = s_q.rcap;
			end
		end

		// software writes to data registers take priority over hardware
		if (wr_en && idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_LOW)) begin
			s_d.rcap[7:0] = pwdata[7:0];
		end
		if (wr_en && idx_hit(paddr, t2crb_pkg::T2CRB_IDX_RCAP_HIGH)) begin
			s_d.rcap[15:8] = pwdata[7:0];
		end
		if (wr_en && idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_LOW)) begin
			s_d.count[7:0] = pwdata[7:0];
		end
		if (wr_en && idx_hit(paddr, t2crb_pkg::T2CRB_IDX_COUNT_HIGH)) begin
			s_d.count[15:8] = pwdata[7:0];
		end
		if (wr_mode) begin
			s_d.mode.auto_clear_ext_irq   = pwdata[t2crb_pkg::T2CRB_MOD_HC_LSB +: 4];
			s_d.mode.capture_clear_enable = pwdata[t2crb_pkg::T2CRB_MOD_CCLR];
			s_d.mode.clock_out_enable     = pwdata[t2crb_pkg::T2CRB_MOD_OE];
			s_d.mode.down_count_enable    = pwdata[t2crb_pkg::T2CRB_MOD_DOWN_COUNT_ENABLE];
		end
		if (wr_ctl) begin
			s_d.ctl = t2crb_pkg::t2crb_ctl_type'(pwdata[7:0]);
		end

		// hardware set wins over a software clear in the same cycle
		if (ovf && !baud) begin
			s_d.ctl.ovf_flag = 1'b1;
		end
		if (edge_act || (ovf && dn_mode)) begin
			s_d.ctl.ext_flag = 1'b1;
		end

		s_d.rx_tick = s_q.ctl.rx_baud_select ? (up_ovf & baud) : timer1_overflow;
		s_d.tx_tick = s_q.ctl.tx_baud_select ? (up_ovf & baud) : timer1_overflow;

		if (!s_q.mode.clock_out_enable) begin
			s_d.clk_out = 1'b0;
		end else if (ovf) begin
			s_d.clk_out = ~s_q.clk_out;
		end

		s_d.irq_clear = ext_irq_ack & s_q.mode.auto_clear_ext_irq;

		if (psel && !penable) begin
			s_d.rdata = rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata        = s_q.rdata;
	assign ext_irq_clear = s_q.irq_clear;
	assign rx_baud_tick  = s_q.rx_tick;
	assign tx_baud_tick  = s_q.tx_tick;
	assign clock_out     = s_q.clk_out;
	assign clock_out_oe  = s_q.mode.clock_out_enable;
	// level request; software write of the external flag also raises it
	assign timer_irq     = s_q.ctl.ovf_flag | s_q.ctl.ext_flag;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_ovf_sets;
		@(posedge pclk) disable iff (!presetn)
		(ovf && !baud) |=> s_q.ctl.ovf_flag;
	endproperty
	a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

	property p_baud_no_flag;
		@(posedge pclk) disable iff (!presetn)
		(baud && !wr_ctl && !s_q.ctl.ovf_flag) |=> !s_q.ctl.ovf_flag;
	endproperty
	a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud mode");

	property p_dn_match;
		@(posedge pclk) disable iff (!presetn)
		(dn_match && !wr_cnt) |=> (s_q.count == 16'hffff) && s_q.ctl.ovf_flag;
	endproperty
	a_dn_match: assert property (p_dn_match) else $error("down match not handled");

	property p_ext_edge;
		@(posedge pclk) disable iff (!presetn)
		edge_act |=> s_q.ctl.ext_flag && timer_irq;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("external flag missed");

	property p_run_hold;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.ctl.run_control && !wr_cnt && !edge_act) |=> $stable(s_q.count);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

	property p_reload;
		@(posedge pclk) disable iff (!presetn)
		(up_ovf && reload_mode && !edge_act && !wr_cnt) |=> (s_q.count == $past(s_q.rcap));
	endproperty
	a_reload: assert property (p_reload) else $error("reload value not loaded");

	property p_capture;
		@(posedge pclk) disable iff (!presetn)
		(edge_act && s_q.ctl.capture_reload_select && !wr_rcap)
			|=> (s_q.rcap == $past(s_q.count));
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_capclr;
		@(posedge pclk) disable iff (!presetn)
		(edge_act && s_q.ctl.capture_reload_select && s_q.mode.capture_clear_enable
			&& !wr_cnt) |=> (s_q.count == 16'h0000);
	endproperty
	a_capclr: assert property (p_capclr) else $error("count not cleared on capture");

	property p_baud_pulse;
		@(posedge pclk) disable iff (!presetn)
		(up_ovf && baud && s_q.ctl.rx_baud_select) |=> rx_baud_tick ##1 !rx_baud_tick;
	endproperty
	a_baud_pulse: assert property (p_baud_pulse) else $error("baud pulse wrong");

	property p_baud_rate;
		@(posedge pclk) disable iff (!presetn)
		(tick && baud && $stable(baud)) |=> !tick ##1 (tick || !s_q.ctl.run_control || !baud);
	endproperty
	a_baud_rate: assert property (p_baud_rate) else $error("baud tick not every 2");

	property p_hc;
		@(posedge pclk) disable iff (!presetn)
		(ext_irq_ack[0] && s_q.mode.auto_clear_ext_irq[0]) |=> ext_irq_clear[0];
	endproperty
	a_hc: assert property (p_hc) else $error("auto clear not issued");

	property p_count_up;
		@(posedge pclk) disable iff (!presetn)
		(tick && !down && !up_ovf && !edge_act && !wr_cnt)
			|=> (s_q.count == 16'($past(s_q.count) + 16'h0001));
	endproperty
	a_count_up: assert property (p_count_up) else $error("count did not advance");

	property p_count_down;
		@(posedge pclk) disable iff (!presetn)
		(tick && s_q.mode.down_count_enable && !s_q.ctl.capture_reload_select && !baud
			&& !s_q.trig_s2 && !dn_match && !wr_cnt)
			|=> (s_q.count == 16'($past(s_q.count) - 16'h0001));
	endproperty
	a_count_down: assert property (p_count_down) else $error("count did not go down");

	property p_capture_wrap;
		@(posedge pclk) disable iff (!presetn)
		(up_ovf && s_q.ctl.capture_reload_select && !baud && !edge_act && !wr_cnt)
			|=> (s_q.count == 16'h0000);
	endproperty
	a_capture_wrap: assert property (p_capture_wrap) else $error("wrap not zero");

	property p_edge_reload;
		@(posedge pclk) disable iff (!presetn)
		(edge_act && !s_q.ctl.capture_reload_select && !wr_cnt)
			|=> (s_q.count == $past(s_q.rcap));
	endproperty
	a_edge_reload: assert property (p_edge_reload) else $error("edge reload wrong");

	property p_rcap_hold;
		@(posedge pclk) disable iff (!presetn)
		(!edge_act && !wr_rcap) |=> $stable(s_q.rcap);
	endproperty
	a_rcap_hold: assert property (p_rcap_hold) else $error("reload register moved");

	property p_sw_flag;
		@(posedge pclk) disable iff (!presetn)
		(wr_ctl && !ovf) |=> (s_q.ctl.ovf_flag == $past(pwdata[t2crb_pkg::T2CRB_CTL_OVF]));
	endproperty
	a_sw_flag: assert property (p_sw_flag) else $error("overflow flag write lost");

	property p_trig_sync;
		@(posedge pclk) disable iff (!presetn)
		trig_fall |-> (!$past(trigger_pin, 2) && $past(trigger_pin, 3));
	endproperty
	a_trig_sync: assert property (p_trig_sync) else $error("trigger fall not synced");

	property p_clk_off;
		@(posedge pclk) disable iff (!presetn)
		!s_q.mode.clock_out_enable |=> !clock_out;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock out while disabled");

	property p_clk_toggle;
		@(posedge pclk) disable iff (!presetn)
		(ovf && s_q.mode.clock_out_enable) |=> (clock_out != $past(clock_out));
	endproperty
	a_clk_toggle: assert property (p_clk_toggle) else $error("clock out did not toggle");

	property p_tx_timer1;
		@(posedge pclk) disable iff (!presetn)
		!s_q.ctl.tx_baud_select |=> (tx_baud_tick == $past(timer1_overflow));
	endproperty
	a_tx_timer1: assert property (p_tx_timer1) else $error("tx tick not from timer 1");

	property p_rx_timer1;
		@(posedge pclk) disable iff (!presetn)
		!s_q.ctl.rx_baud_select |=> (rx_baud_tick == $past(timer1_overflow));
	endproperty
	a_rx_timer1: assert property (p_rx_timer1) else $error("rx tick not from timer 1");

endmodule

// file: testbench/t2crb_far_model.sv
// far-side model: trigger and count pins, timer 1 overflow, serial 0 baud inputs
`timescale 1ns/1ps
module t2crb_far_model (
	input  wire logic pclk,
	input  wire logic rx_baud_tick,
	input  wire logic tx_baud_tick,
	output logic      trigger_pin,
	output logic      count_input_pin,
	output logic      timer1_overflow
);
	int rx_seen = 0;
	int tx_seen = 0;

	// port lines idle high, as pulled-up pins do
	initial begin
		trigger_pin = 1'b1;
		count_input_pin = 1'b1;
		timer1_overflow = 1'b0;
	end

	// the serial port sees one baud edge per high cycle of a tick
	always @(posedge pclk) begin
		if (rx_baud_tick === 1'b1) rx_seen++;
		if (tx_baud_tick === 1'b1) tx_seen++;
	end

	// each level held three cycles so the two-flop synchroniser sees it
	task automatic pin_pulse(input bit trig, input int n);
		repeat (n) begin
			if (trig) trigger_pin <= 1'b0; else count_input_pin <= 1'b0;
			repeat (3) @(posedge pclk);
			trigger_pin <= 1'b1;
			count_input_pin <= 1'b1;
			repeat (3) @(posedge pclk);
		end
	endtask

	task automatic t1_pulse(input int n);
		repeat (n) begin
			timer1_overflow <= 1'b1;
			@(posedge pclk);
			timer1_overflow <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
endmodule

// file: testbench/t2crb_timer_tb_top.sv
// self-checking testbench for the timer 2 capture/reload/baud block
`timescale 1ns/1ps
module t2crb_timer_tb_top;
	localparam logic [9:0] CTL  = t2crb_pkg::T2CRB_IDX_CONTROL;
	localparam logic [9:0] MODE = t2crb_pkg::T2CRB_IDX_MODE;
	localparam logic [9:0] RCL  = t2crb_pkg::T2CRB_IDX_RCAP_LOW;
	localparam logic [9:0] RCH  = t2crb_pkg::T2CRB_IDX_RCAP_HIGH;
	localparam logic [9:0] CNL  = t2crb_pkg::T2CRB_IDX_COUNT_LOW;
	localparam logic [9:0] CNH  = t2crb_pkg::T2CRB_IDX_COUNT_HIGH;
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        trig;
	logic        cnt_pin;
	logic        speed;
	logic        t1_ovf;
	logic [3:0]  irq_ack;
	logic [3:0]  irq_clr;
	logic        rx_tick;
	logic        tx_tick;
	logic        clk_out;
	logic        clk_oe;
	logic        irq;
	logic [32:0] exp_q[$];
	logic [32:0] mon_e;
	logic [7:0]  r8;
	int          bad_count = 0;
	int          n_compared = 0;
	int          clk_edges = 0;
	int          k;
	int          j;

	t2crb_timer i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trigger_pin(trig),
		.count_input_pin(cnt_pin), .tick_speed_select(speed), .timer1_overflow(t1_ovf),
		.ext_irq_ack(irq_ack), .ext_irq_clear(irq_clr), .rx_baud_tick(rx_tick),
		.tx_baud_tick(tx_tick), .clock_out(clk_out), .clock_out_oe(clk_oe),
		.timer_irq(irq));
	t2crb_far_model i_far (.pclk(pclk), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
		.trigger_pin(trig), .count_input_pin(cnt_pin), .timer1_overflow(t1_ovf));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(clk_out) clk_edges++;

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		n_compared++;
		if (got !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, e, got);
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// apb master: called just after a rising edge
	// ----------------------------------------------------------------
	task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [7:0] e);
		exp_q.push_back({1'b0, 24'h00_0000, e});
		apb(idx, 1'b0, 8'h00);
	endtask

	// read results are judged where the access completes
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			mon_e = exp_q.pop_front();
			chk("prdata", mon_e[31:0], prdata);
			chk("pslverr", {31'h0, mon_e[32]}, {31'h0, pslverr});
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h16c6513c));
		{psel, penable, pwrite, speed, presetn} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		irq_ack = 4'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pready", 32'h0000_0001, {31'h0, pready});
		for (k = 0; k < 6; k++) rd(CTL + k[9:0], 8'h00);
		exp_q.push_back({1'b1, 32'h0000_0000});
		apb(10'h0c0, 1'b0, 8'h00);
		for (k = 2; k < 6; k++) begin
			r8 = 8'($urandom);
			apb(CTL + k[9:0], 1'b1, r8);
			rd(CTL + k[9:0], r8);
		end
		apb(MODE, 1'b1, 8'hff);
		rd(MODE, 8'hfb);
		apb(CTL, 1'b1, 8'hc0);
		chk("timer_irq", 32'h0000_0001, {31'h0, irq});
		rd(CTL, 8'hc0);
		apb(CTL, 1'b1, 8'h00);
		chk("timer_irq", 32'h0000_0000, {31'h0, irq});
		apb(MODE, 1'b1, 8'ha0);
		r8 = 8'($urandom);
		irq_ack <= r8[3:0];
		@(posedge pclk);
		irq_ack <= 4'h0;
		@(negedge pclk);
		chk("ext_irq_clear", {28'h0, r8[3:0] & 4'ha}, {28'h0, irq_clr});
		@(posedge pclk);
		apb(MODE, 1'b1, 8'h00);
		// -------------------- up count and reload --------------------
		speed <= 1'b1;
		apb(RCL, 1'b1, 8'hf0);
		apb(RCH, 1'b1, 8'hff);
		apb(CNL, 1'b1, 8'hfe);
		apb(CNH, 1'b1, 8'hff);
		apb(CTL, 1'b1, 8'h04);
		repeat (30) @(posedge pclk);
		rd(CTL, 8'h84);
		apb(CTL, 1'b1, 8'h00);
		rd(CNH, 8'hff);
		chk("clock_out", 32'h0000_0000, {31'h0, clk_out});
		// -------------------- capture --------------------
		apb(CNL, 1'b1, 8'h34);
		apb(CNH, 1'b1, 8'h12);
		apb(CTL, 1'b1, 8'h07);
		i_far.pin_pulse(1'b1, 1);
		rd(RCL, 8'hf0);
		apb(MODE, 1'b1, 8'h08);
		apb(CTL, 1'b1, 8'h0f);
		i_far.pin_pulse(1'b1, 1);
		rd(RCL, 8'h34);
		rd(RCH, 8'h12);
		rd(CNH, 8'h00);
		rd(CTL, 8'h4f);
		i_far.pin_pulse(1'b0, 3);
		rd(CNL, 8'h03);
		apb(CTL, 1'b1, 8'h08);
		i_far.pin_pulse(1'b1, 1);
		rd(CNL, 8'h34);
		rd(CNH, 8'h12);
		apb(CTL, 1'b1, 8'h00);
		// -------------------- down count to the reload value --------------------
		apb(RCL, 1'b1, 8'h10);
		apb(RCH, 1'b1, 8'h00);
		apb(CNL, 1'b1, 8'h12);
		apb(CNH, 1'b1, 8'h00);
		apb(MODE, 1'b1, 8'h01);
		i_far.trigger_pin <= 1'b0;
		apb(CTL, 1'b1, 8'h04);
		repeat (20) @(posedge pclk);
		rd(CTL, 8'hc4);
		apb(CTL, 1'b1, 8'h00);
		rd(CNH, 8'hff);
		i_far.trigger_pin <= 1'b1;
		// -------------------- baud generation --------------------
		apb(MODE, 1'b1, 8'h02);
		apb(RCL, 1'b1, 8'hfc);
		apb(RCH, 1'b1, 8'hff);
		apb(CTL, 1'b1, 8'h25);
		chk("clock_out_oe", 32'h0000_0001, {31'h0, clk_oe});
		k = i_far.rx_seen;
		j = i_far.tx_seen;
		i_far.t1_pulse(5);
		repeat (55) @(posedge pclk);
		chk("tx from timer1", 32'd5, 32'(i_far.tx_seen - j));
		chk("rx ticks", 32'd1, 32'((i_far.rx_seen - k) inside {[9:11]}));
		chk("clock_out toggles", 32'd1, 32'(clk_edges > 7));
		rd(CTL, 8'h25);
		apb(CTL, 1'b1, 8'h14);
		j = i_far.tx_seen;
		repeat (40) @(posedge pclk);
		chk("tx ticks", 32'd1, 32'((i_far.tx_seen - j) inside {[4:6]}));
		report_and_stop();
	end
endmodule
